// File: hdl/ssc_device.sv
// Codec end: signaling channel, pin status, persistence checking and modes.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module ssc_device (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  ssc_link_if.dev lnk,
  input wire logic [11:0] ind_pin,
  input wire logic [7:0] prog_in,
  output logic [7:0] prog_out,
  output logic [7:0] prog_oe,
  output logic [11:0] cmd_pin,
  input wire logic [31:0] voice_tx,
  output logic [31:0] voice_rx,
  output logic [3:0] chan_active,
  output logic basic_mode
);
  import ssc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] dcl_s;
    logic [1:0] fsc_s;
    logic [1:0] dd_s;
    logic [1:0] rst_s;
    logic dcl_d;
    logic [19:0] pin_m;
    logic [19:0] pin_s;
    ssc_mode_type mode;
    logic [3:0] powered;
    logic [5:0] bit_idx;
    logic [63:0] rx_sh;
    logic [63:0] tx_sh;
    logic [3:0][7:0] cfg;
    logic [1:0][7:0] timing;
    logic [1:0][7:0] dir;
    logic [3:0][4:0] cand;
    logic [3:0][4:0] acc;
    logic [3:0][6:0] stab;
    logic [3:0] irq;
    logic [7:0] rsp;
    logic [3:0][2:0] cmd_pin;
    logic [3:0][1:0] prog_out;
    logic [3:0][1:0] prog_en;
    logic [31:0] voice_rx;
    logic du_out;
    logic du_oe;
  } ssc_dev_state_type;

  // The link clock idles high, so its synchroniser starts high as well.
  // Otherwise a false rising edge would follow every reset.
  localparam ssc_dev_state_type RESET_STATE = '{mode: MODE_BASIC, dcl_s: 2'b11, dcl_d: 1'b1,
                                               default: '0};

  ssc_dev_state_type s;
  ssc_dev_state_type next_s;

  // Basic setting: registers to zero, pins to inputs, outputs to ground except basic_mode, which goes high, and voice_rx, which keeps its value.
  function automatic ssc_dev_state_type to_basic(input ssc_dev_state_type st);
    ssc_dev_state_type r;
    r = st;
    r.mode = MODE_BASIC;
    r.powered = '0;
    r.cfg = '0;
    r.timing = '0;
    r.dir = '0;
    r.cand = '0;
    r.acc = '0;
    r.stab = '0;
    r.irq = '0;
    r.rsp = REG_RESET;
    r.cmd_pin = '0;
    r.prog_out = '0;
    r.prog_en = '0;
    r.du_out = 1'b0;
    r.du_oe = 1'b0;
    return r;
  endfunction : to_basic

  // Direction bits of a channel: first channel of a pair uses bits 3:2.
  function automatic logic [1:0] dir_of(input ssc_dev_state_type st, input int c);
    return (c % 2 == 0) ? st.dir[c / 2][3:2] : st.dir[c / 2][7:6];
  endfunction : dir_of

  function automatic logic [7:0] status_of(input ssc_dev_state_type st, input int p);
    logic [4:0] a;
    logic [4:0] b;
    a = st.acc[2 * p];
    b = st.acc[2 * p + 1];
    return {b[PIN_SB1], b[PIN_SB0], b[PIN_SI0], b[PIN_SI0],
            a[PIN_SB1], a[PIN_SB0], a[PIN_SI0], a[PIN_SI0]};
  endfunction : status_of

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic [5:0] cur_idx;
    logic [63:0] f;
    logic [7:0] cmd;
    logic [7:0] dat;
    logic [5:0] ci;
    logic [4:0] smp;
    logic [1:0] dv;
    logic [6:0] lim;
    logic [6:0] nstab;
    logic [4:0] nacc;
    int tgt;
    int p;
    rise = 1'b0;
    fall = 1'b0;
    cur_idx = '0;
    f = '0;
    cmd = '0;
    dat = '0;
    ci = '0;
    smp = '0;
    dv = '0;
    lim = '0;
    nstab = '0;
    nacc = '0;
    tgt = 0;
    p = 0;
    next_s = s;
    next_s.dcl_s = {s.dcl_s[0], lnk.dcl};
    next_s.fsc_s = {s.fsc_s[0], lnk.fsc};
    next_s.dd_s = {s.dd_s[0], lnk.dd};
    next_s.rst_s = {s.rst_s[0], lnk.reset_pin};
    next_s.dcl_d = s.dcl_s[1];
    for (int c = 0; c < NCH; c++) begin
      next_s.pin_m[c * PIN_W +: PIN_W] = {prog_in[2 * c +: 2], ind_pin[3 * c +: 3]};
    end
    next_s.pin_s = s.pin_m;
    rise = s.dcl_s[1] & ~s.dcl_d;
    fall = ~s.dcl_s[1] & s.dcl_d;
    cur_idx = s.fsc_s[1] ? 6'h00 : s.bit_idx;
    if (rise) begin
      next_s.bit_idx = cur_idx + 6'h01;
      next_s.rx_sh = {s.rx_sh[62:0], s.dd_s[1]};
    end
    if (fall && s.mode == MODE_RUN) begin
      next_s.du_out = s.tx_sh[63];
      next_s.tx_sh = {s.tx_sh[62:0], 1'b0};
    end
    if (s.mode == MODE_BASIC && rise && s.fsc_s[1] && !s.rst_s[1]) begin
      next_s.mode = MODE_RUN;
      next_s.du_oe = 1'b1;
    end
    // Downstream data is only decoded outside basic setting.
    if (s.mode == MODE_RUN && rise && cur_idx == LAST_BIT) begin
      f = {s.rx_sh[62:0], s.dd_s[1]};
      cmd = f[CMD_LSB +: 8];
      dat = f[DATA_LSB +: 8];
      next_s.rsp = REG_RESET;
      // A read of pin status clears that pair, before new events are added.
      if (cmd[7:6] == CMD_EXTENDED && cmd[5] && cmd[1:0] == XSEL_PIN_STATUS) begin
        p = int'(cmd[4]);
        next_s.rsp = status_of(s, p);
        next_s.irq[2 * p] = 1'b0;
        next_s.irq[2 * p + 1] = 1'b0;
      end
      for (int c = 0; c < NCH; c++) begin
        dv = dir_of(s, c);
        smp = ~s.pin_s[c * PIN_W +: PIN_W];
        smp[PIN_SB0] = smp[PIN_SB0] & ~dv[0];
        smp[PIN_SB1] = smp[PIN_SB1] & ~dv[1];
        lim = 7'(int'(s.timing[c / 2][7:4]) * FRAMES_PER_MS);
        nacc = s.acc[c];
        if (lim == 7'h00) begin
          nacc = smp;
          next_s.cand[c] = smp;
          next_s.stab[c] = 7'h00;
        end else if (smp != s.cand[c]) begin
          next_s.cand[c] = smp;
          next_s.stab[c] = 7'h00;
        end else begin
          nstab = (s.stab[c] < lim) ? s.stab[c] + 7'h01 : s.stab[c];
          next_s.stab[c] = nstab;
          if (nstab == lim) begin
            nacc = s.cand[c];
          end
        end
        next_s.acc[c] = nacc;
        // Each channel detects on its own, whatever the neighbour holds.
        if (|((nacc ^ s.acc[c]) & IRQ_PIN_MASK)) begin
          next_s.irq[c] = 1'b1;
        end
        if (s.powered[c]) begin
          next_s.voice_rx[8 * c +: 8] = f[VOICE_MSB - 8 * c -: 8];
        end
      end
      for (int q = 0; q < NPAIR; q++) begin
        ci = (q == 0) ? f[CI0_LSB +: 6] : f[CI1_LSB +: 6];
        tgt = ci[5] ? 2 * q : 2 * q + 1;
        next_s.cmd_pin[tgt] = ~ci[2:0];
        dv = dir_of(s, tgt);
        for (int k = 0; k < 2; k++) begin
          if (dv[k]) begin
            next_s.prog_out[tgt][k] = ~ci[3 + k];
          end
        end
      end
      unique case (cmd[7:6])
        CMD_NOP: begin
        end
        CMD_OPERATION: begin
          next_s.powered[cmd[1:0]] = cmd[2];
        end
        CMD_EXTENDED: begin
          p = int'(cmd[4]);
          if (cmd[5]) begin
            if (cmd[1:0] == XSEL_TIMING) begin
              next_s.rsp = s.timing[p];
            end else if (cmd[1:0] == XSEL_DIRECTION) begin
              next_s.rsp = s.dir[p];
            end
          end else if (cmd[1:0] == XSEL_TIMING) begin
            next_s.timing[p] = dat;
          end else if (cmd[1:0] == XSEL_DIRECTION) begin
            next_s.dir[p] = dat & DIRECTION_MASK;
          end
        end
        CMD_COEFFICIENT: begin
          if (!cmd[5] && cmd[4]) begin
            next_s.rsp = s.cfg[cmd[1:0]];
          end else if (!cmd[5]) begin
            next_s.cfg[cmd[1:0]] = dat;
          end
        end
      endcase
      // Upstream frame for the next period.
      for (int c = 0; c < NCH; c++) begin
        next_s.tx_sh[VOICE_MSB - 8 * c -: 8] = s.powered[c] ? voice_tx[8 * c +: 8] : IDLE_VOICE;
      end
      for (int q = 0; q < NPAIR; q++) begin
        ci = {next_s.irq[2 * q], next_s.acc[2 * q][PIN_SI2], next_s.acc[2 * q][PIN_SI1],
              next_s.irq[2 * q + 1], next_s.acc[2 * q + 1][PIN_SI2],
              next_s.acc[2 * q + 1][PIN_SI1]};
        if (q == 0) begin
          next_s.tx_sh[CI0_LSB +: 6] = ci;
        end else begin
          next_s.tx_sh[CI1_LSB +: 6] = ci;
        end
      end
      next_s.tx_sh[CMD_LSB +: 8] = next_s.rsp;
      next_s.tx_sh[11:0] = '0;
      if (cmd[7:6] == CMD_COEFFICIENT && cmd[5]) begin
        next_s = to_basic(next_s);
      end
    end
    for (int c = 0; c < NCH; c++) begin
      if (next_s.mode == MODE_RUN) begin
        next_s.prog_en[c] = dir_of(next_s, c);
      end
    end
    if (s.rst_s[1] || s.mode == MODE_BASIC && next_s.mode == MODE_BASIC) begin
      next_s = to_basic(next_s);
    end
  end

  // ----------------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= RESET_STATE;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign lnk.du_out = s.du_out;
  assign lnk.du_oe = s.du_oe;
  assign prog_out = s.prog_out;
  assign prog_oe = s.prog_en;
  assign cmd_pin = s.cmd_pin;
  assign voice_rx = s.voice_rx;
  assign chan_active = s.powered;
  assign basic_mode = s.mode[0];

endmodule : ssc_device

// File: hdl/ssc_pkg.sv
// Shared constants and types for the signaling channel link and its two ends.
package ssc_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int NCH = 4;
  localparam int NPAIR = 2;
  localparam int PIN_W = 5;
  localparam logic [5:0] LAST_BIT = 6'h3F;
  localparam int VOICE_MSB = 63;
  localparam int CI0_LSB = 26;
  localparam int CI1_LSB = 20;
  localparam int CMD_LSB = 12;
  localparam int DATA_LSB = 4;

  // ----------------------------------------------------------------------
  // Pin vector positions per channel, and the pins that raise interrupts
  // ----------------------------------------------------------------------
  localparam int PIN_SI0 = 0;
  localparam int PIN_SI1 = 1;
  localparam int PIN_SI2 = 2;
  localparam int PIN_SB0 = 3;
  localparam int PIN_SB1 = 4;
  localparam logic [4:0] IRQ_PIN_MASK = 5'h19;

  // ----------------------------------------------------------------------
  // Commands: top two bits give the kind
  // ----------------------------------------------------------------------
  localparam logic [1:0] CMD_NOP = 2'h0;
  localparam logic [1:0] CMD_OPERATION = 2'h1;
  localparam logic [1:0] CMD_EXTENDED = 2'h2;
  localparam logic [1:0] CMD_COEFFICIENT = 2'h3;
  localparam logic [1:0] XSEL_PIN_STATUS = 2'h1;
  localparam logic [1:0] XSEL_TIMING = 2'h2;
  localparam logic [1:0] XSEL_DIRECTION = 2'h3;
  localparam logic [7:0] DIRECTION_MASK = 8'hCC;

  // ----------------------------------------------------------------------
  // Reset values and idle codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] IDLE_VOICE = 8'hFF;
  localparam logic RESET_PIN_RESET = 1'b1;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int FRAME_RATE_HZ = 8000;
  localparam int FRAMES_PER_MS = FRAME_RATE_HZ / 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int DCL_PERIOD_NS = 64;
  localparam logic [3:0] DCL_HALF_CYCLES = 4'(DCL_PERIOD_NS / (2 * CLK_PERIOD_NS));

  // ----------------------------------------------------------------------
  // Controller register addresses
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_CI_TX0 = 4'h0;
  localparam logic [3:0] ADDR_CI_TX1 = 4'h1;
  localparam logic [3:0] ADDR_COMMAND = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_RESPONSE = 4'h4;
  localparam logic [3:0] ADDR_RESET_CTL = 4'h5;

  typedef enum logic [1:0] {
    MODE_BASIC = 2'b01,
    MODE_RUN = 2'b10
  } ssc_mode_type;

endpackage : ssc_pkg

// File: hdl/ssc_link_if.sv
// Serial signaling link between the line-card controller and the codec.
`timescale 1ns/10ps
interface ssc_link_if;
  logic dcl;
  logic fsc;
  logic dd;
  logic reset_pin;
  logic du_out;
  logic du_oe;
  logic du;

  // The upstream line idles high through a pull-up while the codec is off it.
  assign du = du_oe ? du_out : 1'b1;

  modport dev (input dcl, input fsc, input dd, input reset_pin, output du_out, output du_oe);
  modport ctl (output dcl, output fsc, output dd, output reset_pin, input du);
endinterface : ssc_link_if

// File: hdl/ssc_controller.sv
// Line-card controller end: makes the link clock and frames, exposes registers.
`timescale 1ns/10ps
module ssc_controller (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  ssc_link_if.ctl lnk,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [31:0] voice_tx,
  output logic [31:0] voice_rx
);
  import ssc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] du_s;
    logic [3:0] div;
    logic dcl;
    logic fsc;
    logic dd;
    logic rst_pin;
    logic [5:0] bit_idx;
    logic [63:0] tx_sh;
    logic [63:0] rx_sh;
    logic [1:0][5:0] ci_tx;
    logic [15:0] cmd_word;
    logic cmd_pend;
    logic [1:0][5:0] ci_rx;
    logic [7:0] rsp;
    logic [31:0] voice_rx;
    logic [15:0] rdata;
  } ssc_ctl_state_type;

  // Reset pin starts asserted so the codec surely reaches basic setting.
  localparam ssc_ctl_state_type RESET_STATE = '{dcl: 1'b1, rst_pin: RESET_PIN_RESET,
                                               bit_idx: LAST_BIT, default: '0};

  ssc_ctl_state_type s;
  ssc_ctl_state_type next_s;

  always_comb begin
    logic [63:0] f;
    logic cmd_wr;
    f = '0;
    cmd_wr = wr && addr == ADDR_COMMAND;
    next_s = s;
    next_s.du_s = {s.du_s[0], lnk.du};
    next_s.rdata = '0;
    if (wr) begin
      unique case (addr)
        ADDR_CI_TX0: next_s.ci_tx[0] = wdata[5:0];
        ADDR_CI_TX1: next_s.ci_tx[1] = wdata[5:0];
        ADDR_COMMAND: begin
          next_s.cmd_word = wdata;
          next_s.cmd_pend = 1'b1;
        end
        ADDR_RESET_CTL: next_s.rst_pin = wdata[0];
        default: begin
        end
      endcase
    end
    if (rd) begin
      unique case (addr)
        ADDR_CI_TX0: next_s.rdata = {10'h000, s.ci_tx[0]};
        ADDR_CI_TX1: next_s.rdata = {10'h000, s.ci_tx[1]};
        ADDR_COMMAND: next_s.rdata = s.cmd_word;
        ADDR_STATUS: next_s.rdata = {3'h0, s.cmd_pend, s.ci_rx[1], s.ci_rx[0]};
        ADDR_RESPONSE: next_s.rdata = {8'h00, s.rsp};
        ADDR_RESET_CTL: next_s.rdata = {15'h0000, s.rst_pin};
        default: next_s.rdata = '0;
      endcase
    end
    if (s.div == DCL_HALF_CYCLES - 4'h1) begin
      next_s.div = '0;
      next_s.dcl = ~s.dcl;
      if (s.dcl) begin
        // Falling edge: drive the next bit, starting a frame after the last.
        if (s.bit_idx == LAST_BIT) begin
          for (int c = 0; c < NCH; c++) begin
            f[VOICE_MSB - 8 * c -: 8] = voice_tx[8 * c +: 8];
          end
          f[CI0_LSB +: 6] = s.ci_tx[0];
          f[CI1_LSB +: 6] = s.ci_tx[1];
          f[DATA_LSB +: 16] = s.cmd_pend ? s.cmd_word : 16'h0000;
          next_s.bit_idx = '0;
          next_s.fsc = 1'b1;
          next_s.dd = f[63];
          next_s.tx_sh = {f[62:0], 1'b0};
          // A command written in this very cycle stays pending for the next frame.
          next_s.cmd_pend = cmd_wr;
        end else begin
          next_s.bit_idx = s.bit_idx + 6'h01;
          next_s.fsc = 1'b0;
          next_s.dd = s.tx_sh[63];
          next_s.tx_sh = {s.tx_sh[62:0], 1'b0};
        end
      end else begin
        f = {s.rx_sh[62:0], s.du_s[1]};
        next_s.rx_sh = f;
        if (s.bit_idx == LAST_BIT) begin
          next_s.ci_rx[0] = f[CI0_LSB +: 6];
          next_s.ci_rx[1] = f[CI1_LSB +: 6];
          next_s.rsp = f[CMD_LSB +: 8];
          for (int c = 0; c < NCH; c++) begin
            next_s.voice_rx[8 * c +: 8] = f[VOICE_MSB - 8 * c -: 8];
          end
        end
      end
    end else begin
      next_s.div = s.div + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= RESET_STATE;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign lnk.dcl = s.dcl;
  assign lnk.fsc = s.fsc;
  assign lnk.dd = s.dd;
  assign lnk.reset_pin = s.rst_pin;
  assign rdata = s.rdata;
  assign voice_rx = s.voice_rx;

endmodule : ssc_controller

// File: bench/ssc_link_assertions.sv
// Timing assertions on the serial link between controller and codec.
`timescale 1ns/10ps
module ssc_link_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dcl,
  input wire logic fsc,
  input wire logic dd,
  input wire logic reset_pin,
  input wire logic du_out,
  input wire logic du_oe
);
  logic [10:0] fcnt;
  logic fseen;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------------
  // Frame length counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fcnt <= 11'h000;
      fseen <= 1'b0;
    end else begin
      fcnt <= $rose(fsc) ? 11'h001 : fcnt + 11'h001;
      fseen <= fseen | $rose(fsc);
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  a_dcl_high_half: assert property ($rose(dcl) |=> dcl [*7] ##1 !dcl)
    else $error("link clock high phase wrong");
  a_dcl_low_half: assert property ($fell(dcl) |=> !dcl [*7] ##1 dcl)
    else $error("link clock low phase wrong");
  a_fsc_one_bit: assert property ($rose(fsc) |=> fsc [*8] ##1 fsc [*7] ##1 !fsc)
    else $error("frame start not one bit long");
  a_frame_sixty_four: assert property ($rose(fsc) && fseen |-> fcnt == 11'h400)
    else $error("frame is not 64 bits long");
  a_fsc_on_fall: assert property ($changed(fsc) |-> !dcl)
    else $error("frame start moved while link clock high");
  a_dd_on_fall: assert property ($changed(dd) |-> !dcl)
    else $error("downstream data moved while link clock high");
  a_du_on_fall: assert property (du_oe && $changed(du_out) |-> !dcl)
    else $error("upstream data moved while link clock high");
  a_du_frame_start: assert property ($rose(du_oe) |-> fsc && !reset_pin)
    else $error("upstream drive began outside frame start");
  a_du_off_reset: assert property (reset_pin [*6] |-> !du_oe)
    else $error("upstream driven while codec reset held");

  c_du_on: cover property ($rose(du_oe));
  c_pin_reset: cover property ($rose(reset_pin));
  c_soft_reset: cover property ($fell(du_oe) && !reset_pin);
endmodule : ssc_link_assertions

// File: bench/ssc_tb.sv
// Testbench joining the controller and the codec back to back over the link.
`timescale 1ns/10ps
module ssc_tb;
  import ssc_pkg::*;
  localparam int FR = 128 * int'(DCL_HALF_CYCLES);
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [11:0] ind_pin = 12'hFFF;
  logic [7:0] prog_in = 8'h00;
  logic [7:0] prog_out;
  logic [7:0] prog_oe;
  logic [11:0] cmd_pin;
  logic [31:0] ctl_voice_rx;
  logic [3:0] chan_active;
  logic basic_mode;
  logic [15:0] s;
  int err_total = 0;
  int n_compared = 0;

  ssc_link_if lnk ();
  ssc_controller i_ssc_controller (.clk(clk), .rstn(rstn), .ce(1'b1), .lnk(lnk.ctl),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .voice_tx(32'h0000_0000), .voice_rx(ctl_voice_rx));
  ssc_device i_ssc_device (.clk(clk), .rstn(rstn), .ce(1'b1), .lnk(lnk.dev),
    .ind_pin(ind_pin), .prog_in(prog_in), .prog_out(prog_out), .prog_oe(prog_oe),
    .cmd_pin(cmd_pin), .voice_tx(32'h1234_5678), .voice_rx(),
    .chan_active(chan_active), .basic_mode(basic_mode));
  ssc_link_assertions i_ssc_link_assertions (.clk(clk), .rstn(rstn), .dcl(lnk.dcl),
    .fsc(lnk.fsc), .dd(lnk.dd), .reset_pin(lnk.reset_pin), .du_out(lnk.du_out),
    .du_oe(lnk.du_oe));

  always #2 clk = ~clk;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic summarize();
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 s = rdata;
  endtask : bus_rd

  task automatic wait_fr(input int n);
    repeat (n * FR) @(posedge clk);
  endtask : wait_fr

  // A command rides one frame and acts at its end, so three frames always cover it.
  task automatic cmd_wr(input logic [15:0] w);
    bus_wr(ADDR_COMMAND, w);
    wait_fr(3);
  endtask : cmd_wr

  // Soft reset leaves basic mode within a frame, so the wait polls every cycle.
  task automatic wait_basic(input logic v);
    int i;
    for (i = 0; i < 3 * FR && basic_mode !== v; i++) @(posedge clk);
    check("basic_mode", 32'(v), 32'(basic_mode));
    if (basic_mode !== v) summarize();
  endtask : wait_basic

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    @(posedge clk);
    #1;
    check("reset state", 32'h0000_2000, 32'({prog_oe, basic_mode, lnk.du_oe, cmd_pin}));
    bus_wr(ADDR_RESET_CTL, 16'h0000);
    wait_basic(1'b0);
    check("chan_active", 32'h0, 32'(chan_active));
  endtask : t_reset

  task automatic t_down();
    bus_wr(ADDR_CI_TX0, 16'h0025);
    wait_fr(3);
    check("cmd ch0", 32'h2, 32'(cmd_pin[2:0]));
    bus_wr(ADDR_CI_TX0, 16'h001A);
    wait_fr(3);
    check("cmd pair", 32'h2A, 32'(cmd_pin[5:0]));
    check("prog idle", 32'h0, 32'({prog_oe, prog_out}));
    cmd_wr(16'h830C);
    bus_wr(ADDR_CI_TX0, 16'h0030);
    wait_fr(3);
    check("prog drive", 32'h0301, 32'({prog_oe, prog_out}));
    check("cmd ch0 inv", 32'h7, 32'(cmd_pin[2:0]));
    cmd_wr(16'h8300);
  endtask : t_down

  task automatic t_up_irq();
    ind_pin <= 12'hFDD;
    wait_fr(4);
    cmd_wr(16'hA100);
    cmd_wr(16'hB100);
    bus_rd(ADDR_STATUS);
    check("status fwd", 32'h000A, 32'(s));
    check("idle voice", 32'hFFFF_FFFF, ctl_voice_rx);
    @(posedge clk);
    ind_pin <= 12'hFD5;
    wait_fr(4);
    bus_rd(ADDR_STATUS);
    check("irq second", 32'h000E, 32'(s));
    @(posedge clk);
    ind_pin <= 12'hFD4;
    wait_fr(4);
    bus_rd(ADDR_STATUS);
    check("irq both", 32'h002E, 32'(s));
    cmd_wr(16'hA100);
    wait_fr(1);
    bus_rd(ADDR_STATUS);
    check("irq cleared", 32'h000A, 32'(s));
  endtask : t_up_irq

  task automatic t_power();
    cmd_wr(16'h4400);
    cmd_wr(16'h4600);
    wait_fr(2);
    check("power up", 32'h5, 32'(chan_active));
    check("voice ch2 ch1", 32'h34FF, 32'(ctl_voice_rx[23:8]));
    cmd_wr(16'h4000);
    check("power down", 32'h4, 32'(chan_active));
  endtask : t_power

  task automatic t_resets();
    cmd_wr(16'h830C);
    bus_wr(ADDR_COMMAND, 16'hE000);
    wait_basic(1'b1);
    wait_basic(1'b0);
    check("soft cleared", 32'h0, 32'({chan_active, prog_oe}));
    wait_fr(2);
    bus_wr(ADDR_RESET_CTL, 16'h0001);
    repeat (8) @(posedge clk);
    check("pin reset", 32'h2000, 32'({basic_mode, lnk.du_oe, cmd_pin}));
    bus_wr(ADDR_RESET_CTL, 16'h0000);
    wait_basic(1'b0);
  endtask : t_resets

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_down();
    t_up_irq();
    t_power();
    t_resets();
    summarize();
  end
endmodule : ssc_tb
